// [common/column_loader_pkg.sv]
// Purpose: Shared constants and types for the column data loader
// Assumes: 125 MHz core clock, Avalon-MM byte addressing
// Notes:   Counts are in shift-clock words unless stated otherwise
package column_loader_pkg;

  // ----------------------------------------------------------------
  // Pixel word geometry
  // ----------------------------------------------------------------
  localparam int DOT_W         = 6;    // Bits per dot code
  localparam int DOTS_PER_WORD = 3;    // Dots per shift clock
  localparam int WORD_W        = 18;   // Pixel word width
  localparam int NUM_COLS      = 402;  // Column outputs, full mode
  localparam int PHYS_WORDS    = 134;  // Word slots in the data register
  localparam int SYNC_W        = 22;   // Pins passed through synchroniser

  // ----------------------------------------------------------------
  // Chain lengths and skipped window
  // ----------------------------------------------------------------
  localparam logic [7:0] WORDS_FULL     = 8'h86; // 134 words, 402 outputs
  localparam logic [7:0] WORDS_REDUCED  = 8'h80; // 128 words, 384 outputs
  localparam logic [7:0] SKIP_FROM_WORD = 8'h40; // Word 64 = column 192
  localparam logic [7:0] SKIP_WORDS     = 8'h06; // 18 columns skipped

  // ----------------------------------------------------------------
  // Register map (byte offsets) and control fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  STATUS_OFS    = 4'h4;
  localparam int          CTRL_DIR_BIT  = 0;  // 1: right start is input
  localparam int          CTRL_OSEL_BIT = 1;  // 1: 402 outputs
  localparam int          CTRL_INV_BIT  = 2;  // 1: invert loaded data
  localparam logic [2:0]  CTRL_RESET    = 3'h3;
  localparam int          STAT_CNT_LSB  = 8;

  // ----------------------------------------------------------------
  // Gray-scale reference decode
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_MIN  = 6'h00;
  localparam logic [5:0] CODE_MAX  = 6'h3F;
  localparam logic [3:0] REF_FIRST = 4'h0;
  localparam logic [3:0] REF_LAST  = 4'h9;
  localparam logic [2:0] PAIR_LOW  = 3'h0;
  localparam logic [2:0] PAIR_HIGH = 3'h7;
  localparam logic [2:0] STEP_TOP  = 3'h7;
  localparam logic [2:0] STEP_EDGE = 3'h6;

  // Loader sequencing
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_DONE = 3'b100
  } load_state_t;

endpackage

// [common/pin_sync_if.sv]
// Purpose: Carries synchronised panel-side pins into the loader core
// Assumes: Driven only by the pin synchroniser
// Notes:   All fields are second-stage flip-flop outputs
`timescale 1ns/1ps
interface pin_sync_if;
  logic        shift_clk;   // Shift clock level
  logic        strobe;      // Latch strobe level
  logic        start_right; // Right start pulse level
  logic        start_left;  // Left start pulse level
  logic [17:0] pixel;       // Three dot codes

  modport sync_src (output shift_clk, strobe, start_right, start_left,
                    pixel);
  modport core_dst (input shift_clk, strobe, start_right, start_left,
                    pixel);
endinterface

// [rtl/pin_synchroniser.sv]
// Purpose: Two-flop synchroniser for every asynchronous panel pin
// Assumes: Pins are quasi-static relative to the 8 ns core period
// Notes:   Data and clock share depth so their alignment is kept
`timescale 1ns/1ps
module pin_synchroniser
  import column_loader_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  // Raw pins
  input  wire logic [SYNC_W-1:0] raw_in,
  // Synchronised view
  pin_sync_if.sync_src           sync_out
);

  logic [SYNC_W-1:0] stage1_reg; // Read only by stage2_reg
  logic [SYNC_W-1:0] stage2_reg; // Safe for logic

  // --------------------------------------------------------------
  // Two stages, no logic between them
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= raw_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out.shift_clk   = stage2_reg[0];
  assign sync_out.strobe      = stage2_reg[1];
  assign sync_out.start_right = stage2_reg[2];
  assign sync_out.start_left  = stage2_reg[3];
  assign sync_out.pixel       = stage2_reg[SYNC_W-1:4];

endmodule

// [rtl/gray_ref_decoder.sv]
// Purpose: Maps a 6-bit dot code to a reference pair and step
// Assumes: Level = V(ref) + (V(ref-1) - V(ref)) * step / (7 or 8)
// Notes:   Outer pairs split into seven steps, inner ones into eight
`timescale 1ns/1ps
module gray_ref_decoder
  import column_loader_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  // Latched dot code
  input  wire logic [DOT_W-1:0] code_in,
  // D/A selection
  output logic      [3:0]       ref_out,     // Base reference index
  output logic      [2:0]       step_out,    // Steps toward ref-1
  output logic                  seventh_out  // 1: seven-step pair
);

  logic [2:0] pair;  // Upper three bits
  logic [2:0] low;   // Lower three bits

  assign pair = code_in[5:3];
  assign low  = code_in[2:0];

  // --------------------------------------------------------------
  // Registered decode
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ref_out     <= REF_FIRST;
      step_out    <= '0;
      seventh_out <= 1'b0;
    end else if (code_in == CODE_MIN) begin
      ref_out     <= REF_FIRST;
      step_out    <= '0;
      seventh_out <= 1'b1;
    end else if (code_in == CODE_MAX) begin
      ref_out     <= REF_LAST;
      step_out    <= '0;
      seventh_out <= 1'b1;
    end else begin
      // Pair n sits between V(n+1) and V(n)
      ref_out     <= 4'({1'b0, pair}) + 4'h1;
      // Top pair stops short of V9, which has its own code
      step_out    <= (pair == PAIR_HIGH) ? STEP_EDGE - low
                                         : STEP_TOP - low;
      seventh_out <= (pair == PAIR_LOW) || (pair == PAIR_HIGH);
    end
  end

  // Top code selects the last reference exactly
  ends_exact_a: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (code_in == CODE_MAX) |=> (ref_out == REF_LAST && step_out == 3'h0))
    else $error("top code did not select last reference");

endmodule

// [rtl/column_data_loader.sv]
// Purpose: Pixel capture, cascade start and line latch of a column driver
// Assumes: Panel pins are asynchronous and far slower than core_clk_in
// Notes:   Control bits sit in an Avalon-MM register, status is readable
`timescale 1ns/1ps

// Overview of operation
// - Word is three 6-bit dots, bit 0 LSB
// - Direction picks start input, output and order
// - Start seen high at shift edge begins loading
// - Words captured on shift clock rising edges
// - Cascade start rises at 134th or 128th clock
// - Strobe rise latches full line for D/A
// - Strobe clears the loading position chain
// - Reduced mode skips columns 193-210, 128 words
// - Polarity flip high inverts loaded data
// - Codes map to reference pair and step
module column_data_loader
  import column_loader_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      reset_in,
  // Avalon-MM slave
  input  wire logic [3:0]                avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  // Panel input pins
  input  wire logic                      shift_clk_in,
  input  wire logic                      latch_strobe_in,
  input  wire logic [WORD_W-1:0]         pixel_data_in,
  // Two-way start pulse pins
  input  wire logic                      right_start_pulse_in,
  output logic                           right_start_pulse_out,
  output logic                           right_start_pulse_oe_n_out,
  input  wire logic                      left_start_pulse_in,
  output logic                           left_start_pulse_out,
  output logic                           left_start_pulse_oe_n_out,
  // Latched line and D/A selection
  output logic [NUM_COLS*DOT_W-1:0]      column_outputs_out,
  output logic [NUM_COLS*4-1:0]          gray_ref_out,
  output logic [NUM_COLS*3-1:0]          gray_step_out,
  output logic [NUM_COLS-1:0]            gray_seventh_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pin_sync_if    pins ();                       // Synchronised pins
  logic [2:0]    ctrl_reg;                      // Dir, osel, invert
  logic          wait_reg;                      // Waitrequest source
  logic [31:0]   rdata_reg;                     // Read data hold
  logic          sclk_prev_reg;                 // Shift clock history
  logic          strobe_prev_reg;               // Strobe history
  logic          sclk_rise;                     // Shift edge pulse
  logic          strobe_rise;                   // Strobe edge pulse
  logic          started_reg;                   // First strobe seen
  load_state_t   state_reg;                     // Loader state
  load_state_t   state_next;                    // Loader next state
  logic [7:0]    word_cnt_reg;                  // Words loaded so far
  logic [7:0]    word_idx;                      // Slot in this edge
  logic [7:0]    words_total;                   // Chain length
  logic [7:0]    logical_pos;                   // Position from column 1
  logic [7:0]    phys_idx;                      // Slot with skip applied
  logic          start_sel;                     // Incoming start level
  logic          capture_now;                   // Word taken this cycle
  logic          last_word;                     // Final word of chain
  logic          carry_reg;                     // Outgoing start level
  logic          right_oe_n_reg;                // Right pin enable
  logic          left_oe_n_reg;                 // Left pin enable
  logic [WORD_W-1:0] cap_value;                 // Word after inversion
  logic [WORD_W-1:0] data_reg [PHYS_WORDS];     // Data register
  logic [WORD_W-1:0] line_reg [PHYS_WORDS];     // Latched line
  logic          dir_right;                     // Control field
  logic          osel_full;                     // Control field
  logic          invert;                        // Control field

  assign dir_right = ctrl_reg[CTRL_DIR_BIT];
  assign osel_full = ctrl_reg[CTRL_OSEL_BIT];
  assign invert    = ctrl_reg[CTRL_INV_BIT];

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  pin_synchroniser u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .raw_in      ({pixel_data_in, left_start_pulse_in,
                   right_start_pulse_in, latch_strobe_in, shift_clk_in}),
    .sync_out    (pins)
  );

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle; keeps decode registered
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wait_reg <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data prepared while waitrequest is still high
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && wait_reg) begin
      case (avs_address_in)
        CTRL_OFS:   rdata_reg <= {29'h0000_0000, ctrl_reg};
        STATUS_OFS: rdata_reg <= {16'h0000, word_cnt_reg, 3'h0,
                                  carry_reg, state_reg, started_reg};
        default:    rdata_reg <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Control write lands on the edge that sees waitrequest low
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (avs_write_in && !wait_reg && avs_byteenable_in[0] &&
                 avs_address_in == CTRL_OFS) begin
      ctrl_reg <= avs_writedata_in[2:0];
    end
  end

  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out    = rdata_reg;

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sclk_prev_reg   <= 1'b0;
      strobe_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg   <= pins.shift_clk;
      strobe_prev_reg <= pins.strobe;
    end
  end

  assign sclk_rise   = pins.shift_clk & ~sclk_prev_reg;
  assign strobe_rise = pins.strobe & ~strobe_prev_reg;

  // Device ignores start pulses until its first strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      started_reg <= 1'b0;
    end else if (strobe_rise) begin
      started_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Word addressing
  // ----------------------------------------------------------------
  assign start_sel   = dir_right ? pins.start_right
                                 : pins.start_left;
  assign words_total = osel_full ? WORDS_FULL : WORDS_REDUCED;
  assign word_idx    = (state_reg == ST_LOAD) ? word_cnt_reg : 8'h00;
  assign last_word   = (word_idx == words_total - 8'h01);
  // Start edge itself carries the first word, so chips chain seamlessly
  assign capture_now = sclk_rise &&
                       ((state_reg == ST_IDLE && start_sel &&
                         started_reg) ||
                        state_reg == ST_LOAD);
  // Reverse direction fills from the far column inward
  assign logical_pos = dir_right ? word_idx
                                 : words_total - 8'h01 - word_idx;
  // Reduced mode jumps over the six dead word slots
  assign phys_idx    = (!osel_full && logical_pos >= SKIP_FROM_WORD) ?
                       logical_pos + SKIP_WORDS : logical_pos;
  // Whole-dot complement, so each 6-bit code flips independently
  assign cap_value   = pins.pixel ^ {WORD_W{invert}};

  // ----------------------------------------------------------------
  // Loader state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (capture_now) begin
          state_next = last_word ? ST_DONE : ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (capture_now && last_word) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_DONE;  // Waits for the strobe
      default: state_next = ST_IDLE;
    endcase
    if (strobe_rise) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Position chain, cleared by the strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      word_cnt_reg <= 8'h00;
    end else if (strobe_rise) begin
      word_cnt_reg <= 8'h00;
    end else if (capture_now) begin
      word_cnt_reg <= word_idx + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Cascade start output and pin roles
  // ----------------------------------------------------------------
  // High from the last word edge until the next shift edge or strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      carry_reg <= 1'b0;
    end else if (capture_now && last_word) begin
      carry_reg <= 1'b1;
    end else if (sclk_rise || strobe_rise) begin
      carry_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      right_oe_n_reg <= 1'b1;
      left_oe_n_reg  <= 1'b1;
    end else begin
      right_oe_n_reg <= dir_right;
      left_oe_n_reg  <= ~dir_right;
    end
  end

  assign right_start_pulse_out      = carry_reg;
  assign left_start_pulse_out       = carry_reg;
  assign right_start_pulse_oe_n_out = right_oe_n_reg;
  assign left_start_pulse_oe_n_out  = left_oe_n_reg;

  // ----------------------------------------------------------------
  // Data register, line latch and D/A decode, per word slot
  // ----------------------------------------------------------------
  genvar g;
  genvar d;
  generate
    for (g = 0; g < PHYS_WORDS; g++) begin : g_word
      // Word slot written when the pointer lands here
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          data_reg[g] <= '0;
        end else if (capture_now && phys_idx == 8'(g)) begin
          data_reg[g] <= cap_value;
        end
      end
      // Dead slots latch zero in reduced mode
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          line_reg[g] <= '0;
        end else if (strobe_rise) begin
          if (!osel_full && 8'(g) >= SKIP_FROM_WORD &&
              8'(g) < SKIP_FROM_WORD + SKIP_WORDS) begin
            line_reg[g] <= '0;
          end else begin
            line_reg[g] <= data_reg[g];
          end
        end
      end
      assign column_outputs_out[g*WORD_W +: WORD_W] = line_reg[g];
      // Dot d of a word drives column 3*g+d, bit 0 is the LSB
      for (d = 0; d < DOTS_PER_WORD; d++) begin : g_dot
        gray_ref_decoder u_dec (
          .core_clk_in (core_clk_in),
          .reset_in    (reset_in),
          .code_in     (line_reg[g][d*DOT_W +: DOT_W]),
          .ref_out     (gray_ref_out[(g*3+d)*4 +: 4]),
          .step_out    (gray_step_out[(g*3+d)*3 +: 3]),
          .seventh_out (gray_seventh_out[g*3+d])
        );
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence start_seen_s;
    sclk_rise && state_reg == ST_IDLE && start_sel && started_reg &&
    !strobe_rise;
  endsequence

  sequence last_word_s;
    capture_now && last_word && !strobe_rise;
  endsequence

  start_loads_a: assert property (start_seen_s |=>
    (state_reg != ST_IDLE && word_cnt_reg == 8'h01))
    else $error("start pulse did not begin loading");

  word_capture_a: assert property (capture_now |=>
    data_reg[$past(phys_idx)] == $past(cap_value))
    else $error("captured word not stored at its slot");

  carry_rise_a: assert property (last_word_s |=>
    (carry_reg && state_reg == ST_DONE))
    else $error("cascade start not raised on last word");

  carry_count_a: assert property ($rose(carry_reg) |->
    $past(word_idx) == words_total - 8'h01)
    else $error("cascade start raised at wrong word count");

  pin_roles_a: assert property (dir_right |=>
    (right_oe_n_reg && !left_oe_n_reg))
    else $error("start pin directions wrong");

  line_latch_a: assert property ((strobe_rise && osel_full) |=>
    (line_reg[0] == $past(data_reg[0]) &&
     line_reg[PHYS_WORDS-1] == $past(data_reg[PHYS_WORDS-1])))
    else $error("strobe did not latch data register");

  // A last-word capture in the strobe cycle still raises the carry
  strobe_clear_a: assert property (
    (strobe_rise && !(capture_now && last_word)) |=>
    (state_reg == ST_IDLE && word_cnt_reg == 8'h00 && !carry_reg))
    else $error("strobe did not clear position chain");

  no_early_load_a: assert property (!started_reg && !strobe_rise |=>
    state_reg == ST_IDLE)
    else $error("loading before first strobe");

  skip_cols_a: assert property ((strobe_rise && !osel_full) |=>
    (line_reg[64] == '0 && line_reg[69] == '0))
    else $error("skipped columns not blanked");

  invert_a: assert property ((capture_now && invert) |=>
    (data_reg[$past(phys_idx)] == ~$past(pins.pixel)))
    else $error("inversion not applied");

endmodule

// [testbench/panel_ctrl_model.sv]
// Purpose: Timing controller model driving the panel-side pins
// Assumes: Every pin phase lasts 4 core cycles, above the sync minimum
// Notes:   Shift clock idles low between lines
`timescale 1ns/1ps
module panel_ctrl_model (
  // Clock
  input  wire logic        core_clk_in,
  // Panel pins
  output logic             shift_clk_out,
  output logic             strobe_out,
  output logic             start_out,
  output logic [17:0]      pixel_out
);
  // Pins quiet at time zero
  initial begin
    shift_clk_out = 1'b0;
    strobe_out = 1'b0;
    start_out = 1'b0;
    pixel_out = 18'h00000;
  end
  // One pin phase
  task automatic hold4();
    repeat (4) @(posedge core_clk_in);
  endtask
  // One word per shift clock; start rides on the first word only
  task automatic word(input logic [17:0] d, input logic st);
    pixel_out <= d;
    start_out <= st;
    hold4();
    shift_clk_out <= 1'b1;
    hold4();
    shift_clk_out <= 1'b0;
    start_out <= 1'b0;
    pixel_out <= ~d;          // Released data never shows a stale word
    hold4();
  endtask
  // Line latch pulse, then time for latch and decode to settle
  task automatic strobe();
    strobe_out <= 1'b1;
    hold4();
    strobe_out <= 1'b0;
    repeat (8) @(posedge core_clk_in);
  endtask
endmodule

// [testbench/column_data_loader_tb.sv]
// Purpose: Self-checking bench for the column data loader
// Assumes: Bus answer comes once waitrequest drops
// Notes:   Full 134 and 128 word lines are sent
`timescale 1ns/1ps
module column_data_loader_tb;
  import column_loader_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic wreq, ro, roe, lo, loe, sc, sb, st;
  logic [WORD_W-1:0] px;
  logic [NUM_COLS*DOT_W-1:0] col;
  logic [NUM_COLS*4-1:0] gr;
  logic [NUM_COLS*3-1:0] gs;
  logic [NUM_COLS-1:0] g7;
  int err_total = 0, n_compared = 0;
  always #4 clk = ~clk;
  panel_ctrl_model m (.core_clk_in(clk), .shift_clk_out(sc),
    .strobe_out(sb), .start_out(st), .pixel_out(px));
  // Each start pin sees the model where it is an input
  column_data_loader dut (.core_clk_in(clk), .reset_in(rst),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .shift_clk_in(sc), .latch_strobe_in(sb), .pixel_data_in(px),
    .right_start_pulse_in(roe ? st : ro), .right_start_pulse_out(ro),
    .right_start_pulse_oe_n_out(roe),
    .left_start_pulse_in(loe ? st : lo), .left_start_pulse_out(lo),
    .left_start_pulse_oe_n_out(loe), .column_outputs_out(col),
    .gray_ref_out(gr), .gray_step_out(gs), .gray_seventh_out(g7));
  task automatic chk(input logic ok, input string s);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, s);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Dot d of word w carries code 3w+d
  function automatic logic [17:0] wd(input int w);
    return {6'(3*w+2), 6'(3*w+1), 6'(3*w)};
  endfunction
  // Cascade start must be low before the last word, high after it
  task automatic line(input int n, input logic dir);
    for (int i = 0; i < n; i++) begin
      m.word(wd(i), i == 0);
      if (i >= n - 2) begin
        chk((dir ? lo : ro) === (i == n-1), "carry");
        chk((dir ? loe : roe) === 1'b0, "out pin");
      end
    end
  endtask
  task automatic s_regs();
    bus(1'b0, CTRL_OFS, 32'h0, q);
    chk(q[2:0] === CTRL_RESET, "ctrl reset");
    bus(1'b1, 4'h8, 32'h4, q);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q === 32'h0, "unmapped read");
    bus(1'b0, CTRL_OFS, 32'h0, q);
    chk(q[2:0] === CTRL_RESET, "unmapped write");
  endtask
  // Right loading, 402 outputs, plain data
  task automatic s_right();
    m.strobe();
    line(134, 1'b1);
    bus(1'b0, STATUS_OFS, 32'h0, q);
    chk(q[15:0] === {WORDS_FULL, 8'h19}, "line done");
    m.strobe();
    chk(col[11:0] === 12'h040, "cols 0 1");
    chk(col[2411:2406] === 6'h11, "col 401");
    chk({gr[7:4], gs[5:3], g7[1]} === 8'h1D, "decode");
    chk({gr[255:252], gs[191:189]} === 7'h48, "top code");
    bus(1'b0, STATUS_OFS, 32'h0, q);
    chk(q[15:0] === 16'h0003, "cleared");
  endtask
  // Left loading, 384 outputs, inverted data
  task automatic s_left();
    bus(1'b1, CTRL_OFS, 32'h4, q);
    line(128, 1'b0);
    m.strobe();
    chk(col[5:0] === 6'h02, "left col 0");
    chk(col[1271:1266] === 6'h01, "col 211");
    chk(col[2411:2406] === 6'h3D, "left col 401");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_right();
    s_left();
    print_verdict();
  end
  // Watchdog well beyond the roughly 3200 cycles needed
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
